// *** design/flpc_control.sv ***
// Flash LED pulse-programmed controller: pin decode, pulse counting,
// start-up sequencing, 1X/2X switchover, timeout and protection handling.
// Assumes enable and flash-select pins already synchronous to clock.
`timescale 1ns/10ps
`default_nettype none
module flpc_control
    import flpc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int SOFT_CYCLES = SOFT_CYC,
    parameter int OFF_CYCLES = OFF_CYC,
    parameter int SHORT_CYCLES = SHORT_CYC,
    parameter int LONG_CYCLES = LONG_CYC
) (
    input wire logic clock, // 125 MHz
    input wire logic reset_n, // Synchronous, active low
    input wire logic enable_pin, // Enable and pulse input
    input wire logic flash_pin, // Flash select / PWM input
    input wire flpc_pkg::flpc_sense_t sense, // Analog comparators
    output flpc_pkg::flpc_drive_t drive, // Pump controls
    output logic [8:0] target_mv // Torch target, zero in flash
);
    import flpc_pkg::*;

    function automatic logic [3:0] level_of(input logic [4:0] n);
        logic [2:0] idx;
        idx = 3'(n - 5'h01);
        level_of = LEVEL_FULL - {1'b0, idx} * LEVEL_STEP;
    endfunction

    ////////////////////////////////////////////////////////////////////
    flpc_state_t state_reg;
    logic en_d_reg;
    logic [4:0] count_reg;
    logic [26:0] off_cnt_reg;
    logic [26:0] seq_cnt_reg;
    logic [27:0] flash_cnt_reg;
    logic [13:0] mode_cnt_reg;
    logic pump_2x_reg;
    logic timed_out_reg;
    logic rise;
    logic off_long;
    logic flash_req;
    assign rise = enable_pin & ~en_d_reg;
    // A rising enable ends shutdown at once, so it still counts as pulse one
    assign off_long = !enable_pin && (off_cnt_reg >= 27'(OFF_CYCLES));
    assign flash_req = enable_pin & flash_pin;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            en_d_reg <= 1'b0;
        end else begin
            en_d_reg <= enable_pin;
        end
    end

    // Enable low time, saturating at the shutdown length
    always_ff @(posedge clock) begin
        if (!reset_n || enable_pin) begin
            off_cnt_reg <= '0;
        end else if (!off_long) begin
            off_cnt_reg <= off_cnt_reg + 27'h000_0001;
        end
    end

    // Edges are counted in any state; the count holds at sixteen until shutdown
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (off_long) begin
            count_reg <= '0;
        end else if (rise && count_reg != CNT_MAX) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start-up sequence; a long enable low drops back to off
    always_ff @(posedge clock) begin
        if (!reset_n || off_long) begin
            state_reg <= FLPC_OFF;
            seq_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                FLPC_OFF: begin
                    seq_cnt_reg <= '0;
                    if (enable_pin) begin
                        state_reg <= FLPC_WAKE;
                    end
                end
                FLPC_WAKE: begin
                    if (seq_cnt_reg >= 27'(WAKE_CYCLES - 1)) begin
                        seq_cnt_reg <= '0;
                        state_reg <= FLPC_SOFT;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 27'h000_0001;
                    end
                end
                FLPC_SOFT: begin
                    if (sense.temp_trip) begin
                        state_reg <= FLPC_FAULT;
                    end else if (seq_cnt_reg >= 27'(SOFT_CYCLES - 1)) begin
                        seq_cnt_reg <= '0;
                        state_reg <= FLPC_RUN;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 27'h000_0001;
                    end
                end
                FLPC_RUN: begin
                    if (sense.temp_trip) begin
                        state_reg <= FLPC_FAULT;
                    end
                end
                FLPC_FAULT: begin
                    seq_cnt_reg <= '0;
                    if (sense.temp_cool) begin
                        state_reg <= FLPC_SOFT;
                    end
                end
                default: state_reg <= FLPC_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Persistence timer restarts whenever the watched condition breaks
    logic mode_cond;
    assign mode_cond = pump_2x_reg ? sense.headroom_ok : sense.fb_below_ref;
    always_ff @(posedge clock) begin
        if (!reset_n || state_reg != FLPC_RUN) begin
            pump_2x_reg <= 1'b0;
            mode_cnt_reg <= '0;
        end else if (!mode_cond || sense.out_short) begin
            mode_cnt_reg <= '0;
        end else if (!pump_2x_reg && mode_cnt_reg >= 14'(UP_CYC - 1)) begin
            pump_2x_reg <= 1'b1;
            mode_cnt_reg <= '0;
        end else if (pump_2x_reg && mode_cnt_reg >= 14'(DOWN_CYC - 1)) begin
            pump_2x_reg <= 1'b0;
            mode_cnt_reg <= '0;
        end else begin
            mode_cnt_reg <= mode_cnt_reg + 14'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flash timer runs only in flash; PWM lows to torch reset it
    // The long limit needs 28 bits at the full clock rate
    logic [27:0] limit;
    assign limit = (count_reg > 5'h08) ? 28'(LONG_CYCLES) : 28'(SHORT_CYCLES);
    always_ff @(posedge clock) begin
        if (!reset_n || !flash_req) begin
            flash_cnt_reg <= '0;
            timed_out_reg <= 1'b0;
        end else if (flash_cnt_reg >= limit - 28'h000_0001) begin
            timed_out_reg <= 1'b1;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 28'h000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Over-voltage latch; a new trip wins over a release in the same cycle
    logic ovp_hold_reg;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ovp_hold_reg <= 1'b0;
        end else if (sense.ovp_high) begin
            ovp_hold_reg <= 1'b1;
        end else if (sense.ovp_low) begin
            ovp_hold_reg <= 1'b0;
        end
    end

    logic run;
    logic use_flash;
    assign run = (state_reg == FLPC_RUN) && enable_pin;
    assign use_flash = run && flash_req && !timed_out_reg;
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            drive <= '0;
            target_mv <= '0;
        end else begin
            drive.active <= (state_reg != FLPC_OFF);
            drive.soft_start <= (state_reg == FLPC_SOFT);
            drive.pump_2x <= pump_2x_reg && !sense.out_short;
            drive.switches_on <= (state_reg == FLPC_RUN ||
                state_reg == FLPC_SOFT) && !sense.ovp_high &&
                !ovp_hold_reg &&
                !sense.out_short;
            drive.flash_mode <= use_flash;
            drive.torch_mode <= run && !use_flash;
            drive.current_fold <= sense.temp_warn;
            drive.short_limit <= sense.out_short;
            drive.level_tenths <= (count_reg == 5'h00) ? LEVEL_FULL :
                level_of(count_reg);
            drive.long_timeout <= (count_reg > 5'h08);
            target_mv <= (run && !use_flash) ? TORCH_TARGET_MV : 9'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_count_sat: assert property (
        @(posedge clock) disable iff (!reset_n)
        count_reg == CNT_MAX && rise |=> count_reg == CNT_MAX)
        else $error("pulse count moved past sixteen");
    a_count_clear: assert property (
        @(posedge clock) disable iff (!reset_n)
        off_long |=> count_reg == 5'h00)
        else $error("pulse count not cleared after shutdown");
    a_count_first: assert property (
        @(posedge clock) disable iff (!reset_n)
        off_long ##1 rise |=> count_reg == 5'h01)
        else $error("first edge after shutdown not pulse one");
    a_count_step: assert property (
        @(posedge clock) disable iff (!reset_n)
        rise && !off_long && count_reg < CNT_MAX
        |=> count_reg == $past(count_reg) + 5'h01)
        else $error("rising edge not counted");
    a_wake_soft: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(state_reg == FLPC_SOFT) && $past(state_reg) == FLPC_WAKE
        |-> $past(seq_cnt_reg) == 27'(WAKE_CYCLES - 1))
        else $error("soft start entered before wake delay");
    a_soft_flag: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_reg == FLPC_SOFT |=> drive.soft_start)
        else $error("soft start not flagged");
    a_start_1x: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(state_reg == FLPC_RUN) |-> !pump_2x_reg)
        else $error("run began outside 1X");
    a_up_2x: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(pump_2x_reg) |-> $past(sense.fb_below_ref, 1) &&
        $past(mode_cnt_reg) == 14'(UP_CYC - 1))
        else $error("2X entered without 8us feedback low");
    a_down_1x: assert property (
        @(posedge clock) disable iff (!reset_n)
        $fell(pump_2x_reg) && $past(state_reg) == FLPC_RUN
        |-> $past(mode_cnt_reg) == 14'(DOWN_CYC - 1))
        else $error("1X resumed without 32us headroom");
    a_flash_sel: assert property (
        @(posedge clock) disable iff (!reset_n)
        drive.flash_mode |-> !drive.torch_mode && target_mv == 9'h000)
        else $error("flash and torch both selected");
    a_torch_tgt: assert property (
        @(posedge clock) disable iff (!reset_n)
        drive.torch_mode |-> target_mv == TORCH_TARGET_MV)
        else $error("torch target not 47mV");
    a_level_range: assert property (
        @(posedge clock) disable iff (!reset_n)
        drive.active |-> drive.level_tenths >= 4'h3 &&
        drive.level_tenths <= LEVEL_FULL)
        else $error("flash level outside thirty to full");
    a_timeout_end: assert property (
        @(posedge clock) disable iff (!reset_n)
        timed_out_reg |=> !drive.flash_mode)
        else $error("flash kept after timeout");
    a_torch_nolimit: assert property (
        @(posedge clock) disable iff (!reset_n)
        !flash_req |=> !timed_out_reg && flash_cnt_reg == '0)
        else $error("flash timer ran outside flash");
    a_ovp_off: assert property (
        @(posedge clock) disable iff (!reset_n)
        sense.ovp_high |=> !drive.switches_on)
        else $error("switches on during over-voltage");
    a_ovp_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        ovp_hold_reg && !sense.ovp_low |=> !drive.switches_on)
        else $error("switches on before output fell back");
    a_short_nopump: assert property (
        @(posedge clock) disable iff (!reset_n)
        sense.out_short |=> !drive.pump_2x && drive.short_limit)
        else $error("pumping during short");
    a_trip_fault: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_reg == FLPC_RUN && sense.temp_trip && !off_long
        |=> state_reg == FLPC_FAULT)
        else $error("thermal trip ignored");
    a_fold: assert property (
        @(posedge clock) disable iff (!reset_n)
        sense.temp_warn |=> drive.current_fold)
        else $error("current not folded back when hot");
    c_ovp: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(ovp_hold_reg));
    c_run: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(state_reg == FLPC_RUN));
    c_2x: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(pump_2x_reg));
    c_timeout: cover property (@(posedge clock) disable iff (!reset_n)
        $rose(timed_out_reg));
    c_long: cover property (@(posedge clock) disable iff (!reset_n)
        count_reg == CNT_MAX);
endmodule
`default_nettype wire

// *** design/flpc_pkg.sv ***
// Constants and carrier types for the flash LED pulse-programmed control.
// Assumes a single 125 MHz clock.
package flpc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int WAKE_US = 50;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int SOFT_US = 450;
    localparam int SOFT_CYC = SOFT_US * CLK_MHZ;
    localparam int UP_US = 8;
    localparam int UP_CYC = UP_US * CLK_MHZ + 1;
    localparam int DOWN_US = 32;
    localparam int DOWN_CYC = DOWN_US * CLK_MHZ + 1;
    localparam int OFF_US = 500;
    localparam int OFF_CYC = OFF_US * CLK_MHZ;
    localparam int SHORT_MS = 220;
    localparam int SHORT_CYC = SHORT_MS * 1000 * CLK_MHZ;
    localparam int LONG_MS = 1300;
    localparam int LONG_CYC = LONG_MS * 1000 * CLK_MHZ;
    localparam int TORCH_MV = 47;
    localparam logic [8:0] TORCH_TARGET_MV = 9'h02F;
    localparam logic [4:0] CNT_MAX = 5'h10;
    localparam logic [3:0] LEVEL_FULL = 4'hA;
    localparam logic [3:0] LEVEL_STEP = 4'h1;

    typedef enum logic [2:0] {
        FLPC_OFF, FLPC_WAKE, FLPC_SOFT, FLPC_RUN, FLPC_FAULT
    } flpc_state_t;

    // Analog condition flags from the comparators
    typedef struct packed {
        logic fb_below_ref;
        logic headroom_ok;
        logic ovp_high;
        logic ovp_low;
        logic temp_warn;
        logic temp_trip;
        logic temp_cool;
        logic out_short;
    } flpc_sense_t;

    // Pump drive outputs
    typedef struct packed {
        logic active;
        logic soft_start;
        logic pump_2x;
        logic switches_on;
        logic flash_mode;
        logic torch_mode;
        logic current_fold;
        logic short_limit;
        logic [3:0] level_tenths;
        logic long_timeout;
    } flpc_drive_t;
endpackage

// *** tb/flpc_host.sv ***
// Host pin driver model for the flash controller bench.
// Assumes the bench calls one task at a time, just after a falling edge.
`timescale 1ns/10ps
`default_nettype none
module flpc_host #(
    parameter int PHASE = 100,
    parameter int OFF_HOLD = 600,
    parameter int TORCH_WAIT = 300
) (
    input wire logic clock, // Bench clock
    output logic enable_pin, // Enable and pulse line
    output logic flash_pin, // Flash select line
    output flpc_pkg::flpc_sense_t sense // Comparator flag levels
);
    initial begin
        enable_pin = 1'b0;
        flash_pin = 1'b0;
        sense = '0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic shutdown();
        flash_pin = 1'b0;
        enable_pin = 1'b0;
        wait_cyc(OFF_HOLD);
    endtask
    task automatic rise();
        enable_pin = 1'b1;
    endtask
    // Phases sit well inside the window so no edge is doubtful
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                enable_pin = 1'b0;
                wait_cyc(PHASE);
            end
            enable_pin = 1'b1;
            wait_cyc(PHASE);
        end
    endtask
    task automatic set_flash(input logic lvl);
        flash_pin = lvl;
    endtask
    // Comparator flags stand in for the analog side of the driver
    task automatic set_sense(input flpc_pkg::flpc_sense_t s);
        sense = s;
    endtask
    // Torch settles before dimming; wait scaled down to keep runs short
    task automatic torch_wait();
        flash_pin = 1'b0;
        wait_cyc(TORCH_WAIT);
    endtask
    // 500 high plus 2000 low cycles: 50 kHz at 20 percent duty
    task automatic pwm_half(input logic lvl);
        flash_pin = lvl;
        wait_cyc(lvl ? 500 : 2000);
    endtask
endmodule
`default_nettype wire

// *** tb/flpc_control_tb.sv ***
// Self-checking bench for the flash LED pulse-programmed controller.
// Assumes the host model drives the pins and the bench drives the flags.
`timescale 1ns/10ps
`default_nettype none
module flpc_control_tb;
    import flpc_pkg::*;
    logic clock;
    logic reset_n;
    logic enable_pin;
    logic flash_pin;
    flpc_sense_t sense;
    flpc_sense_t flags;
    flpc_drive_t drive;
    logic [8:0] target_mv;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    int counts [5] = '{20, 1, 9, 8, 16};
    flpc_control #(.WAKE_CYCLES(20), .SOFT_CYCLES(30), .OFF_CYCLES(500),
        .SHORT_CYCLES(1000), .LONG_CYCLES(3000)) flpc_control_i (
        .clock(clock), .reset_n(reset_n), .enable_pin(enable_pin),
        .flash_pin(flash_pin), .sense(sense), .drive(drive),
        .target_mv(target_mv));
    flpc_host flpc_host_i (.clock(clock), .enable_pin(enable_pin),
        .flash_pin(flash_pin), .sense(sense));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 31k cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            conclude();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Hand the flag set to the host model, then let cycles pass
    task automatic cycf(input int n);
        flpc_host_i.set_sense(flags);
        cyc(n);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        flpc_host_i.rise();
        cyc(12);
        chk(16'(drive.soft_start), 16'h0000);
        cyc(23);
        chk(16'(drive.soft_start), 16'h0001);
        cyc(40);
        chk(16'({drive.soft_start, drive.torch_mode, drive.pump_2x,
            drive.switches_on}), 16'h0005);
        chk(16'(target_mv), 16'h002F);
        chk(16'({drive.level_tenths, drive.long_timeout}),
            16'h0014);
        $display("startup done");
    endtask
    // A short dip in the low-feedback flag must restart the wait
    task automatic t_switch();
        flags.fb_below_ref = 1'b1;
        cycf(900);
        flags.fb_below_ref = 1'b0;
        cycf(1);
        flags.fb_below_ref = 1'b1;
        cycf(990);
        chk(16'(drive.pump_2x), 16'h0000);
        cyc(25);
        chk(16'(drive.pump_2x), 16'h0001);
        flags.fb_below_ref = 1'b0;
        flags.headroom_ok = 1'b1;
        cycf(3990);
        chk(16'(drive.pump_2x), 16'h0001);
        cyc(25);
        chk(16'(drive.pump_2x), 16'h0000);
        flags.headroom_ok = 1'b0;
        $display("switchover done");
    endtask
    // Each flag change reaches the pins on the next cycf call
    task automatic t_protect();
        flags.ovp_high = 1'b1;
        cycf(5);
        chk(16'(drive.switches_on), 16'h0000);
        flags.ovp_high = 1'b0;
        cycf(20);
        chk(16'(drive.switches_on), 16'h0000);
        flags.ovp_low = 1'b1;
        cycf(5);
        chk(16'(drive.switches_on), 16'h0001);
        flags.ovp_low = 1'b0;
        flags.temp_warn = 1'b1;
        cycf(5);
        chk(16'(drive.current_fold), 16'h0001);
        flags.temp_warn = 1'b0;
        flags.temp_trip = 1'b1;
        cycf(5);
        chk(16'(drive.switches_on), 16'h0000);
        flags.temp_trip = 1'b0;
        flags.temp_cool = 1'b1;
        cycf(5);
        chk(16'(drive.soft_start), 16'h0001);
        flags.temp_cool = 1'b0;
        cycf(60);
        flags.out_short = 1'b1;
        cycf(5);
        chk(16'({drive.short_limit, drive.pump_2x, drive.switches_on}),
            16'h0004);
        flags.out_short = 1'b0;
        cycf(1);
        $display("protection done");
    endtask
    task automatic t_pwm();
        flpc_host_i.shutdown();
        flpc_host_i.pulses(1);
        flpc_host_i.torch_wait();
        for (int i = 0; i < 3; i++) begin
            flpc_host_i.pwm_half(1'b1);
            chk(16'({drive.flash_mode, drive.torch_mode}), 16'h0002);
            flpc_host_i.pwm_half(1'b0);
            chk(16'({drive.flash_mode, drive.torch_mode}), 16'h0001);
        end
        $display("dimming done");
    endtask
    task automatic t_timeout();
        flpc_host_i.shutdown();
        flpc_host_i.pulses(1);
        cyc(1100);
        chk(16'(drive.torch_mode), 16'h0001);
        flpc_host_i.set_flash(1'b1);
        cyc(990);
        chk(16'({drive.flash_mode, drive.torch_mode}), 16'h0002);
        chk(16'(target_mv), 16'h0000);
        cyc(20);
        chk(16'({drive.flash_mode, drive.torch_mode}), 16'h0001);
        flpc_host_i.set_flash(1'b0);
        $display("timeout done");
    endtask
    // Twenty pulses first, so the next count of one shows the clear
    task automatic t_levels();
        int cn;
        for (int i = 0; i < 5; i++) begin
            flpc_host_i.shutdown();
            chk(16'(drive.active), 16'h0000);
            flpc_host_i.pulses(counts[i]);
            flpc_host_i.set_flash(1'b1);
            cyc(5);
            cn = (counts[i] > 16) ? 16 : counts[i];
            chk(16'({drive.flash_mode, drive.level_tenths,
                drive.long_timeout}), 16'h0020 | 16'((10 - (cn - 1) % 8) << 1)
                | 16'(cn > 8));
            flpc_host_i.set_flash(1'b0);
        end
        $display("levels done");
    endtask
    initial begin
        reset_n = 1'b0;
        flags = '0;
        cyc(8);
        reset_n = 1'b1;
        cyc(1);
        t_startup();
        t_switch();
        t_protect();
        t_pwm();
        t_timeout();
        t_levels();
        conclude();
    end
endmodule
`default_nettype wire
